// [verilog/ctr_console_regs.sv]
// Console terminal registers: receive and transmit status and buffers, halt keystroke.
`timescale 1ns/10ps
module ctr_console_regs import ctr_pkg::*; (
	input  wire logic                 clk_in,                // Processor clock.
	input  wire logic                 nrst_in,               // Initialization, active low.
	input  wire logic [CTR_SEL_W-1:0] reg_sel_in,            // Register select.
	input  wire logic                 reg_wr_in,             // Write strobe.
	input  wire logic                 reg_rd_in,             // Read strobe.
	input  wire logic [31:0]          reg_wdata_in,          // Write data.
	output logic [31:0]               reg_rdata_out,         // Read data.
	output logic                      reg_rvalid_out,        // Read data valid pulse.
	output logic                      rx_irq_out,            // Receive interrupt pulse.
	output logic                      tx_irq_out,            // Transmit interrupt pulse.
	output logic [4:0]                interrupt_priority_level_out, // Request level.
	input  wire logic                 term_rx_valid_in,      // Console offers a word.
	output logic                      term_rx_ready_out,     // Block can take it.
	input  wire ctr_rx_word_t         term_rx_word_in,       // Word from console.
	output logic                      term_tx_valid_out,     // Word for console side.
	input  wire logic                 term_tx_ready_in,      // Console side takes it.
	output ctr_tx_word_t              term_tx_word_out,      // Outgoing word.
	input  wire logic                 console_locked_in,     // Console lock switch.
	input  wire logic                 cpu_halted_in,         // Processor halt pulse.
	input  wire logic                 cpu_run_in,            // Processor start pulse.
	output logic                      halt_req_out,          // Halt request pulse.
	output logic                      console_mode_out,      // Console I/O mode level.
	output logic                      cmd_char_valid_out,    // Command character pulse.
	output logic [7:0]                cmd_char_out,          // Command character.
	output logic                      cmdfile_resume_out,    // Resume command file pulse.
	output logic                      boot_req_out,          // Bootstrap request pulse.
	input  wire logic                 restart_begin_in,      // Restart attempt starts.
	input  wire logic                 boot_begin_in,         // Bootstrap attempt starts.
	output logic                      restart_busy_out,      // Restart in progress.
	output logic                      boot_busy_out          // Bootstrap in progress.
);
	logic [1:0]   rst_sync;
	logic         rst_n;
	logic         buf_valid;
	logic         buf_ready;
	ctr_rx_word_t buf_word;
	ctr_mode_t    mode;
	ctr_mode_t    next_mode;
	logic         rx_ready;
	logic         rx_ie;
	ctr_rx_word_t rx_word;
	logic         tx_ready;
	logic         tx_ie;
	logic         tx_pend;
	ctr_tx_word_t tx_word;
	logic         rx_and_q;
	logic         tx_and_q;
	logic         cmdfile_pend;
	logic         next_rx_ready;
	logic         next_rx_ie;
	ctr_rx_word_t next_rx_word;
	logic         next_tx_ready;
	logic         next_tx_ie;
	logic         next_tx_pend;
	ctr_tx_word_t next_tx_word;
	logic         next_cmdfile_pend;
	logic         next_halt_req;
	logic         next_cmd_valid;
	logic [7:0]   next_cmd_char;
	logic         next_resume;
	logic         next_boot_req;
	logic         next_restart_busy;
	logic         next_boot_busy;
	logic [31:0]  next_rdata;
	logic         is_halt_key;
	logic         rd_rx_buf;
	logic         wr_tx_buf;
	ctr_tx_word_t wr_word;
	logic         is_msg;
	// Every check below runs on the processor clock and sleeps through initialization.
	default clocking main_cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// Reset is released through two flops so every flop leaves reset on one edge.
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];
	// Two-entry buffer absorbs the console while software has not read the last word.
	ctr_pair_fifo #(
		.WIDTH($bits(ctr_rx_word_t)),
		.DEPTH(CTR_BUF_DEPTH)
	) u_rx_fifo (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n),
		.in_valid_in  (term_rx_valid_in),
		.in_ready_out (term_rx_ready_out),
		.in_data_in   (term_rx_word_in),
		.out_valid_out(buf_valid),
		.out_ready_in (buf_ready),
		.out_data_out (buf_word)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Decode of the head word and of register accesses.
	assign is_halt_key = (buf_word.source_select_field == CTR_ID_TERMINAL)
		&& (buf_word.data == CTR_HALT_KEY) && !console_locked_in
		&& (mode == CTR_MODE_PROGRAM);
	assign rd_rx_buf = reg_rd_in && (reg_sel_in == CTR_SEL_RX_BUFFER);
	assign wr_tx_buf = reg_wr_in && (reg_sel_in == CTR_SEL_TX_BUFFER) && tx_ready;
	assign wr_word   = ctr_tx_word_t'({reg_wdata_in[CTR_ID_MSB:CTR_ID_LSB],
		reg_wdata_in[CTR_DATA_MSB:0]});
	assign is_msg    = wr_word.source_select_field == CTR_ID_CONSOLE;
	// Halt keys and console-mode characters never wait on the software buffer.
	assign buf_ready = is_halt_key
		|| ((mode == CTR_MODE_CONSOLE) && (buf_word.source_select_field == CTR_ID_TERMINAL))
		|| !rx_ready;
	// Next values of all control state.
	always_comb begin
		next_mode         = mode;
		next_rx_ready     = rx_ready;
		next_rx_ie        = rx_ie;
		next_rx_word      = rx_word;
		next_tx_ready     = tx_ready;
		next_tx_ie        = tx_ie;
		next_tx_pend      = tx_pend;
		next_tx_word      = tx_word;
		next_cmdfile_pend = cmdfile_pend;
		next_halt_req     = 1'b0;
		next_cmd_valid    = 1'b0;
		next_cmd_char     = cmd_char_out;
		next_resume       = 1'b0;
		next_boot_req     = 1'b0;
		next_restart_busy = restart_busy_out;
		next_boot_busy    = boot_busy_out;
		next_rdata        = reg_rdata_out;
		// A read empties the buffer and its side fields.
		if (rd_rx_buf) begin
			next_rx_ready = 1'b0;
			next_rx_word  = '0;
		end
		// Receive side; a load in the read cycle wins, so no word is lost.
		if (buf_valid && is_halt_key) begin
			next_mode     = CTR_MODE_CONSOLE;
			next_halt_req = 1'b1;
		end else if (buf_valid && (mode == CTR_MODE_CONSOLE)
			&& (buf_word.source_select_field == CTR_ID_TERMINAL)) begin
			next_cmd_valid = 1'b1;
			next_cmd_char  = buf_word.data;
		end else if (buf_valid && !rx_ready) begin
			next_rx_ready = 1'b1;
			next_rx_word  = buf_word;
		end
		// Any other halt also puts the console in charge of the terminal.
		if (cpu_halted_in) begin
			next_mode = CTR_MODE_CONSOLE;
		end else if (cpu_run_in) begin
			next_mode = CTR_MODE_PROGRAM;
		end
		// Enable bits are plain read/write.
		if (reg_wr_in && (reg_sel_in == CTR_SEL_RX_CTRL)) begin
			next_rx_ie = reg_wdata_in[CTR_IE_BIT];
		end
		if (reg_wr_in && (reg_sel_in == CTR_SEL_TX_CTRL)) begin
			next_tx_ie = reg_wdata_in[CTR_IE_BIT];
		end
		// Transmit: messages finish at once, other words wait on the console side.
		if (tx_pend && term_tx_ready_in) begin
			next_tx_pend  = 1'b0;
			next_tx_ready = 1'b1;
		end
		if (wr_tx_buf) begin
			next_tx_ready = is_msg;
			if (is_msg) begin
				case (wr_word.data)
					CTR_MSG_SW_DONE:     next_cmdfile_pend = 1'b1;
					CTR_MSG_BOOT:        next_boot_req     = 1'b1;
					CTR_MSG_CLR_RESTART: next_restart_busy = 1'b0;
					CTR_MSG_CLR_BOOT:    next_boot_busy    = 1'b0;
					default:             next_boot_req     = 1'b0;
				endcase
			end else begin
				next_tx_pend = 1'b1;
				next_tx_word = wr_word;
			end
		end
		// Progress flags: a new attempt wins over a clearing message.
		if (restart_begin_in) begin
			next_restart_busy = 1'b1;
		end
		if (boot_begin_in) begin
			next_boot_busy = 1'b1;
		end
		// Resume the command file on the first halt; a fresh done message stays pending.
		if ((cpu_halted_in || (buf_valid && is_halt_key)) && cmdfile_pend) begin
			next_resume       = 1'b1;
			next_cmdfile_pend = wr_tx_buf && is_msg && (wr_word.data == CTR_MSG_SW_DONE);
		end
		// Read data, captured before this cycle's clears.
		if (reg_rd_in) begin
			case (reg_sel_in)
				CTR_SEL_RX_CTRL:   next_rdata = {24'h0, rx_ready, rx_ie, 6'h0};
				CTR_SEL_RX_BUFFER: next_rdata = {16'h0, rx_word.error, 3'h0,
					rx_word.source_select_field, rx_word.data};
				CTR_SEL_TX_CTRL:   next_rdata = {24'h0, tx_ready, tx_ie, 6'h0};
				default:           next_rdata = 32'h0;
			endcase
		end
	end
	// State registers; initialization gives the architectural reset values.
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			mode               <= CTR_MODE_PROGRAM;
			rx_ready           <= CTR_RX_READY_RST;
			rx_ie              <= CTR_IE_RST;
			rx_word            <= '0;
			tx_ready           <= CTR_TX_READY_RST;
			tx_ie              <= CTR_IE_RST;
			tx_pend            <= 1'b0;
			tx_word            <= '0;
			cmdfile_pend       <= 1'b0;
			rx_and_q           <= 1'b0;
			tx_and_q           <= 1'b0;
			halt_req_out       <= 1'b0;
			cmd_char_valid_out <= 1'b0;
			cmd_char_out       <= 8'h00;
			cmdfile_resume_out <= 1'b0;
			boot_req_out       <= 1'b0;
			restart_busy_out   <= 1'b0;
			boot_busy_out      <= 1'b0;
			reg_rdata_out      <= 32'h0;
			reg_rvalid_out     <= 1'b0;
		end else begin
			mode               <= next_mode;
			rx_ready           <= next_rx_ready;
			rx_ie              <= next_rx_ie;
			rx_word            <= next_rx_word;
			tx_ready           <= next_tx_ready;
			tx_ie              <= next_tx_ie;
			tx_pend            <= next_tx_pend;
			tx_word            <= next_tx_word;
			cmdfile_pend       <= next_cmdfile_pend;
			rx_and_q           <= rx_ie && rx_ready;
			tx_and_q           <= tx_ie && tx_ready;
			halt_req_out       <= next_halt_req;
			cmd_char_valid_out <= next_cmd_valid;
			cmd_char_out       <= next_cmd_char;
			cmdfile_resume_out <= next_resume;
			boot_req_out       <= next_boot_req;
			restart_busy_out   <= next_restart_busy;
			boot_busy_out      <= next_boot_busy;
			reg_rdata_out      <= next_rdata;
			reg_rvalid_out     <= reg_rd_in;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Interrupts fire on the rising edge of enable AND ready, whichever came last.
	assign rx_irq_out = rx_ie && rx_ready && !rx_and_q;
	assign tx_irq_out = tx_ie && tx_ready && !tx_and_q;
	assign interrupt_priority_level_out = CTR_IRQ_LEVEL;
	assign term_tx_valid_out = tx_pend;
	assign term_tx_word_out  = tx_word;
	assign console_mode_out  = (mode == CTR_MODE_CONSOLE);
	////////////////////////////////////////////////////////////////////////////////
	// Checks of the register and mode behaviour.
	property p_rx_read_clears;
		(rd_rx_buf && rx_ready) |=> !rx_ready;
	endproperty
	a_rx_read_clears: assert property (p_rx_read_clears) else $error("ready kept after read");
	property p_err_clears;
		(rd_rx_buf && rx_ready) |=> !rx_word.error;
	endproperty
	a_err_clears: assert property (p_err_clears) else $error("error kept after read");
	property p_id_clears;
		(rd_rx_buf && rx_ready) |=> (rx_word.source_select_field == 4'h0);
	endproperty
	a_id_clears: assert property (p_id_clears) else $error("source field kept after read");
	property p_rx_ie_write;
		(reg_wr_in && reg_sel_in == CTR_SEL_RX_CTRL) |=> (rx_ie == $past(reg_wdata_in[CTR_IE_BIT]));
	endproperty
	a_rx_ie_write: assert property (p_rx_ie_write) else $error("receive enable not written");
	property p_tx_ie_write;
		(reg_wr_in && reg_sel_in == CTR_SEL_TX_CTRL) |=> (tx_ie == $past(reg_wdata_in[CTR_IE_BIT]));
	endproperty
	a_tx_ie_write: assert property (p_tx_ie_write) else $error("transmit enable not written");
	property p_rx_irq;
		$rose(rx_ie && rx_ready) |-> rx_irq_out ##1 !rx_irq_out;
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt wrong");
	property p_tx_irq;
		$rose(tx_ie && tx_ready) |-> tx_irq_out ##1 !tx_irq_out;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt wrong");
	property p_halt_key;
		(buf_valid && is_halt_key && !cpu_run_in) |=> (halt_req_out && console_mode_out);
	endproperty
	a_halt_key: assert property (p_halt_key) else $error("halt key did not halt");
	property p_locked_pass;
		(buf_valid && console_locked_in && !rx_ready && mode == CTR_MODE_PROGRAM
			&& buf_word.data == CTR_HALT_KEY) |=> (rx_ready && !halt_req_out);
	endproperty
	a_locked_pass: assert property (p_locked_pass) else $error("locked halt key lost");
	property p_tx_busy;
		(wr_tx_buf && !is_msg) |=> (!tx_ready && term_tx_valid_out);
	endproperty
	a_tx_busy: assert property (p_tx_busy) else $error("transmit ready not cleared");
	property p_msg_boot;
		(wr_tx_buf && is_msg && wr_word.data == CTR_MSG_BOOT) |=> boot_req_out;
	endproperty
	a_msg_boot: assert property (p_msg_boot) else $error("boot message ignored");
	property p_msg_restart;
		(wr_tx_buf && is_msg && wr_word.data == CTR_MSG_CLR_RESTART && !restart_begin_in)
			|=> !restart_busy_out;
	endproperty
	a_msg_restart: assert property (p_msg_restart) else $error("restart flag kept");
	c_halt: cover property (halt_req_out);
	c_rx_irq: cover property (rx_irq_out);
	c_tx_done: cover property (term_tx_valid_out && term_tx_ready_in);
	c_full: cover property (term_rx_valid_in && !term_rx_ready_out);
	c_cmd_char: cover property (cmd_char_valid_out);
endmodule : ctr_console_regs

// [verilog/ctr_pkg.sv]
// Shared constants, types and register selects for the console terminal register block.
package ctr_pkg;
	// Register selects on the internal register port.
	localparam int         CTR_SEL_W          = 2;
	localparam logic [1:0] CTR_SEL_RX_CTRL    = 2'h0;
	localparam logic [1:0] CTR_SEL_RX_BUFFER  = 2'h1;
	localparam logic [1:0] CTR_SEL_TX_CTRL    = 2'h2;
	localparam logic [1:0] CTR_SEL_TX_BUFFER  = 2'h3;
	// Field positions.
	localparam int         CTR_READY_BIT      = 7;
	localparam int         CTR_IE_BIT         = 6;
	localparam int         CTR_ERROR_BIT      = 15;
	localparam int         CTR_ID_LSB         = 8;
	localparam int         CTR_ID_MSB         = 11;
	localparam int         CTR_DATA_MSB       = 7;
	// Values after reset.
	localparam logic       CTR_RX_READY_RST   = 1'b0;
	localparam logic       CTR_TX_READY_RST   = 1'b1;
	localparam logic       CTR_IE_RST         = 1'b0;
	// Source select codes and console message codes.
	localparam logic [3:0] CTR_ID_TERMINAL    = 4'h0;
	localparam logic [3:0] CTR_ID_CONSOLE     = 4'hf;
	localparam logic [7:0] CTR_MSG_SW_DONE    = 8'h01;
	localparam logic [7:0] CTR_MSG_BOOT       = 8'h02;
	localparam logic [7:0] CTR_MSG_CLR_RESTART = 8'h03;
	localparam logic [7:0] CTR_MSG_CLR_BOOT   = 8'h04;
	// Halt keystroke, control-P.
	localparam logic [7:0] CTR_HALT_KEY       = 8'h10;
	// Interrupt priority level of both requests.
	localparam logic [4:0] CTR_IRQ_LEVEL      = 5'h14;
	// Depth of the receive buffer.
	localparam int         CTR_BUF_DEPTH      = 2;

	// Console mode, Gray coded.
	typedef enum logic [1:0] {
		CTR_MODE_PROGRAM = 2'b00,
		CTR_MODE_CONSOLE = 2'b01
	} ctr_mode_t;

	// Word arriving from the console side.
	typedef struct packed {
		logic       error;
		logic [3:0] source_select_field;
		logic [7:0] data;
	} ctr_rx_word_t;

	// Word leaving toward the console side.
	typedef struct packed {
		logic [3:0] source_select_field;
		logic [7:0] data;
	} ctr_tx_word_t;
endpackage : ctr_pkg

// [verilog/ctr_pair_fifo.sv]
// Small FIFO with valid and ready on both sides, used in the receive path.
`timescale 1ns/10ps
module ctr_pair_fifo import ctr_pkg::*; #(
	parameter int WIDTH = 13,
	parameter int DEPTH = CTR_BUF_DEPTH
) (
	input  wire logic             clk_in,       // Clock.
	input  wire logic             rst_n_in,     // Synchronised reset, active low.
	input  wire logic             in_valid_in,  // Word offered.
	output logic                  in_ready_out, // Room for a word.
	input  wire logic [WIDTH-1:0] in_data_in,   // Word in.
	output logic                  out_valid_out, // Word available.
	input  wire logic             out_ready_in, // Drain takes the word.
	output logic [WIDTH-1:0]      out_data_out  // Oldest word.
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////////////
	// Full and empty come straight from the count, so back-pressure is exact.
	assign in_ready_out  = (count != FULL);
	assign out_valid_out = (count != '0);
	assign out_data_out  = mem[rd_ptr];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Pointer and count updates.
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage needs no reset; an empty slot is never read as valid.
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
endmodule : ctr_pair_fifo

// [testbench/ctr_console_model.sv]
// Console side model: offers receive words, takes transmit words after a stall.
`timescale 1ns/10ps
module ctr_console_model import ctr_pkg::*; (
	input  wire logic         clk_in,       // Processor clock.
	input  wire logic         rx_ready_in,  // Block has room.
	output logic              rx_valid_out, // Word offered.
	output ctr_rx_word_t      rx_word_out,  // Word to block.
	input  wire logic         tx_valid_in,  // Block offers a word.
	input  wire ctr_tx_word_t tx_word_in,   // Word from block.
	output logic              tx_ready_out  // Takes the word.
);
	ctr_tx_word_t last_tx;
	int           n_tx = 0;
	int           wait_c = 0;
	int           lim = 4;
	int           n_stall = 0;
	// Idle lines start low and no word is offered.
	initial begin
		rx_valid_out = 1'b0;
		rx_word_out = '0;
		tx_ready_out = 1'b0;
	end
	// Fields settle with valid and hold until taken; then the bus scrambles.
	task automatic send(input ctr_rx_word_t w);
		int i;
		@(negedge clk_in);
		rx_word_out = w;
		rx_valid_out = 1'b1;
		for (i = 0; i < 50 && rx_ready_in !== 1'b1; i++) @(negedge clk_in);
		// A word never taken is counted so the bench can fail the run.
		if (i == 50) n_stall++;
		@(negedge clk_in);
		rx_valid_out = 1'b0;
		rx_word_out = ~w;
	endtask : send
	// A stall of at least four cycles keeps the busy state visible to software.
	always @(negedge clk_in) begin
		wait_c <= (tx_valid_in === 1'b1) ? wait_c + 1 : 0;
		if (tx_valid_in !== 1'b1) lim <= $urandom_range(4, 9);
		tx_ready_out <= tx_valid_in === 1'b1 && wait_c >= lim;
	end
	// The last handed-over word is kept and handovers are counted; messages never reach this side.
	always @(posedge clk_in) begin
		if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
			last_tx <= tx_word_in;
			n_tx <= n_tx + 1;
		end
	end
endmodule : ctr_console_model

// [testbench/console_terminal_registers_tb.sv]
// Self-checking bench for the console terminal register block.
`timescale 1ns/10ps
module console_terminal_registers_tb import ctr_pkg::*;;
	logic clk_in = 0, nrst_in = 0, reg_wr_in = 0, reg_rd_in = 0, reg_rvalid_out;
	logic [1:0] reg_sel_in = 0;
	logic [31:0] reg_wdata_in = 0, reg_rdata_out, v;
	logic rx_irq_out, tx_irq_out, term_rx_valid_in, term_rx_ready_out, term_tx_valid_out;
	logic term_tx_ready_in, console_locked_in = 0, cpu_halted_in = 0, cpu_run_in = 0;
	logic halt_req_out, console_mode_out, cmd_char_valid_out, cmdfile_resume_out;
	logic boot_req_out, restart_begin_in = 0, boot_begin_in = 0;
	logic restart_busy_out, boot_busy_out;
	logic [4:0] interrupt_priority_level_out;
	logic [7:0] cmd_char_out;
	ctr_rx_word_t term_rx_word_in, w;
	ctr_tx_word_t term_tx_word_out;
	int fails = 0, n_compared = 0, ev[6] = '{default: 0}, e[6], k, n;
	always #4 clk_in = ~clk_in;
	ctr_console_regs ctr_console_regs_inst (.clk_in, .nrst_in, .reg_sel_in, .reg_wr_in,
		.reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .rx_irq_out, .tx_irq_out,
		.interrupt_priority_level_out, .term_rx_valid_in, .term_rx_ready_out,
		.term_rx_word_in, .term_tx_valid_out, .term_tx_ready_in, .term_tx_word_out,
		.console_locked_in, .cpu_halted_in, .cpu_run_in, .halt_req_out, .console_mode_out,
		.cmd_char_valid_out, .cmd_char_out, .cmdfile_resume_out, .boot_req_out,
		.restart_begin_in, .boot_begin_in, .restart_busy_out, .boot_busy_out);
	ctr_console_model ctr_console_model_inst (.clk_in, .rx_ready_in(term_rx_ready_out),
		.rx_valid_out(term_rx_valid_in), .rx_word_out(term_rx_word_in),
		.tx_valid_in(term_tx_valid_out), .tx_word_in(term_tx_word_out),
		.tx_ready_out(term_tx_ready_in));
	// Pulses are counted so a scenario can say how many it caused.
	always @(posedge clk_in) begin
		ev[0] <= ev[0] + (rx_irq_out === 1'b1);
		ev[1] <= ev[1] + (tx_irq_out === 1'b1);
		ev[2] <= ev[2] + (halt_req_out === 1'b1);
		ev[3] <= ev[3] + (cmdfile_resume_out === 1'b1);
		ev[4] <= ev[4] + (boot_req_out === 1'b1);
		ev[5] <= ev[5] + (cmd_char_valid_out === 1'b1);
	end
	////////////////////////////////
	function automatic logic [31:0] cs(input logic rdy, input logic ie);
		return {24'h0, rdy, ie, 6'h0};
	endfunction : cs
	function automatic logic [31:0] console_receive_data_buffer(input ctr_rx_word_t x);
		return {16'h0, x.error, 3'h0, x.source_select_field, x.data};
	endfunction : console_receive_data_buffer
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [1:0] s, input logic [31:0] d);
		@(negedge clk_in);
		reg_sel_in = s;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] s, output logic [31:0] d);
		@(negedge clk_in);
		reg_sel_in = s;
		reg_rd_in = 1'b1;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		chk("rvalid", reg_rvalid_out, 1'b1);
		d = reg_rdata_out;
	endtask : rd
	// Polling is bounded; a ready bit that never comes ends the run.
	task automatic wait_rdy(input logic [1:0] s);
		int i;
		for (i = 0; i < 30; i++) begin
			rd(s, v);
			if (v[CTR_READY_BIT] === 1'b1) break;
		end
		if (i == 30) begin
			fails++;
			complete_run();
		end
	endtask : wait_rdy
	task automatic pulse(ref logic s);
		@(negedge clk_in);
		s = 1'b1;
		@(negedge clk_in);
		s = 1'b0;
	endtask : pulse
	task automatic msg(input logic [7:0] d);
		wr(CTR_SEL_TX_BUFFER, {20'h0, CTR_ID_CONSOLE, d});
		repeat (2) @(negedge clk_in);
	endtask : msg
	// Hang guard.
	initial begin
		repeat (50000) @(posedge clk_in);
		fails++;
		complete_run();
	end
	////////////////////////////////
	initial begin
		void'($urandom(32'hdeb2f6d7));
		repeat (20) @(posedge clk_in);
		@(negedge clk_in);
		nrst_in = 1'b1;
		repeat (4) @(negedge clk_in);
		rd(CTR_SEL_RX_CTRL, v);
		chk("rx ctrl", v, cs(0, 0));
		rd(CTR_SEL_TX_CTRL, v);
		chk("tx ctrl", v, cs(1, 0));
		chk("level", interrupt_priority_level_out, 32'h14);
		$display("test reset done");
		// Enable is raised before ready on some words and after it on others.
		for (k = 0; k < 4; k++) begin
			w = ctr_rx_word_t'($urandom);
			if (!k[0]) w.source_select_field = 4'h0;
			if (w.data == CTR_HALT_KEY) w.data = 8'h41;
			e = ev;
			if (k[1]) wr(CTR_SEL_RX_CTRL, 32'h40);
			ctr_console_model_inst.send(w);
			wait_rdy(CTR_SEL_RX_CTRL);
			wr(CTR_SEL_RX_CTRL, 32'h40);
			repeat (2) @(negedge clk_in);
			chk("rx irq", ev[0], e[0] + 1);
			rd(CTR_SEL_RX_BUFFER, v);
			chk("rx buffer", v, console_receive_data_buffer(w));
			rd(CTR_SEL_RX_CTRL, v);
			chk("rx ctrl read", v, cs(0, 1));
			rd(CTR_SEL_RX_BUFFER, v);
			chk("rx cleared", v, 32'h0);
			wr(CTR_SEL_RX_CTRL, 32'h0);
		end
		rd(CTR_SEL_RX_CTRL, v);
		chk("rx ie off", v, cs(0, 0));
		// Two words back to back: the second waits in the buffer and is not lost.
		w = ctr_rx_word_t'($urandom);
		w.source_select_field = 4'h0;
		w.data = 8'h61;
		ctr_console_model_inst.send(w);
		ctr_console_model_inst.send(~w);
		wait_rdy(CTR_SEL_RX_CTRL);
		rd(CTR_SEL_RX_BUFFER, v);
		chk("rx first", v, console_receive_data_buffer(w));
		wait_rdy(CTR_SEL_RX_CTRL);
		rd(CTR_SEL_RX_BUFFER, v);
		chk("rx second", v, console_receive_data_buffer(~w));
		$display("test receive done");
		// A second write while busy must be dropped.
		for (k = 0; k < 4; k++) begin
			e = ev;
			wr(CTR_SEL_TX_CTRL, {25'h0, k[0], 6'h0});
			n = ctr_console_model_inst.n_tx;
			w.data = 8'($urandom);
			wr(CTR_SEL_TX_BUFFER, {24'h0, w.data});
			wr(CTR_SEL_TX_BUFFER, 32'h0ff);
			rd(CTR_SEL_TX_CTRL, v);
			chk("tx busy", v, cs(0, k[0]));
			wait_rdy(CTR_SEL_TX_CTRL);
			repeat (2) @(negedge clk_in);
			chk("tx word", ctr_console_model_inst.last_tx, {24'h0, w.data});
			chk("tx count", ctr_console_model_inst.n_tx, n + 1);
			chk("tx irq", ev[1], e[1] + 2 * k[0]);
		end
		$display("test transmit done");
		e = ev;
		n = ctr_console_model_inst.n_tx;
		pulse(restart_begin_in);
		pulse(boot_begin_in);
		msg(8'h03);
		chk("busy flags", {restart_busy_out, boot_busy_out}, 2'b01);
		msg(8'h04);
		chk("boot busy", boot_busy_out, 1'b0);
		msg(8'h02);
		chk("boot req", ev[4], e[4] + 1);
		msg(8'h01);
		chk("early resume", ev[3], e[3]);
		pulse(cpu_halted_in);
		repeat (2) @(negedge clk_in);
		chk("resume", ev[3], e[3] + 1);
		chk("msg not sent", ctr_console_model_inst.n_tx, n);
		pulse(cpu_run_in);
		repeat (2) @(negedge clk_in);
		chk("program mode", console_mode_out, 1'b0);
		$display("test messages done");
		// The halt key passes as data when locked and halts when unlocked.
		w = '0;
		w.data = CTR_HALT_KEY;
		e = ev;
		console_locked_in = 1'b1;
		ctr_console_model_inst.send(w);
		wait_rdy(CTR_SEL_RX_CTRL);
		rd(CTR_SEL_RX_BUFFER, v);
		chk("locked key", v, console_receive_data_buffer(w));
		console_locked_in = 1'b0;
		ctr_console_model_inst.send(w);
		repeat (4) @(negedge clk_in);
		chk("halt req", ev[2], e[2] + 1);
		chk("console mode", console_mode_out, 1'b1);
		rd(CTR_SEL_RX_CTRL, v);
		chk("key consumed", v, cs(0, 0));
		// In console mode a terminal character goes to the console, not to software.
		w.data = 8'h41;
		e = ev;
		ctr_console_model_inst.send(w);
		repeat (4) @(negedge clk_in);
		chk("cmd char", cmd_char_out, 32'h41);
		chk("cmd pulse", ev[5], e[5] + 1);
		rd(CTR_SEL_RX_CTRL, v);
		chk("char kept from software", v, cs(0, 0));
		chk("stalls", ctr_console_model_inst.n_stall, 0);
		$display("test halt key done");
		complete_run();
	end
endmodule : console_terminal_registers_tb
